// ===== src/tpo_path_alarm.sv
// tx path-overhead alarm and error insertion for one sts-1 envelope
// assumes byte-position flags come aligned with each transmit byte and
// receive defect levels are synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RULE_01] software keeps the b3 mask at zero for clean parity
// [RULE_02] outbound b3 is xored with the mask register
// [RULE_03] bip-8 of each envelope goes into the next envelope's b3
// [RULE_04] ais enable forces every envelope byte to all ones
// [RULE_05] ais enable also forces h1, h2, h3 to all ones
// [RULE_06] no cells or packets are accepted while ais is enabled
// [RULE_07] rdi sources: automatic, software, external overhead port
// [RULE_08] rdi type 00 selects automatic insertion
// [RULE_09] automatic mode writes chosen code into g1 rdi bits
// [RULE_10] plm, uneq, lop, ais, tim and lcd defects can trigger rdi
// [RULE_11] automatic rdi lasts exactly while the defect is declared
// [RULE_12] map 2 bits 3:1 give the plm code
// [RULE_13] map 2 bit 0 enables rdi on plm
// [RULE_14] map 2 holds lcd code in 7:5 and its enable in bit 4
// [RULE_15] map 1 bits 3:1 give the uneq code
// [RULE_16] map 1 bit 0 enables rdi on uneq
// [RULE_17] map 1 bit 4 enables rdi on tim
// [RULE_18] map 1 bits 7:5 give the tim code
// [RULE_19] control 0 holds f2, rei and c2 insertion type fields
// [RULE_20] fixed priority: ais, lop, uneq, tim, plm, lcd
// [RULE_21] no enabled defect in automatic mode sends zero rdi bits
module tpo_path_alarm (
   input wire logic ref_clk, // 100 mhz byte clock
   input wire logic sys_rst, // sync reset, high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic in_valid, // transmit byte strobe
   input wire logic [7:0] in_byte, // transmit byte
   input wire logic in_spe, // byte is in the envelope
   input wire logic in_spe_first, // first envelope byte (j1)
   input wire logic in_b3_pos, // byte is b3
   input wire logic in_g1_pos, // byte is g1
   input wire logic in_ptr_pos, // byte is h1, h2 or h3
   input wire logic [2:0] ext_path_overhead_in, // external rdi code
   input wire logic rx_ais, // receive ais-p declared
   input wire logic rx_lop, // receive lop-p declared
   input wire logic rx_uneq, // receive uneq-p declared
   input wire logic rx_tim, // receive tim-p declared
   input wire logic rx_plm, // receive plm-p declared
   input wire logic rx_lcd, // receive lcd-p declared
   output logic out_valid, // outbound byte strobe
   output logic [7:0] out_byte, // outbound byte
   output logic src_ready, // cell/packet source may send
   output logic [2:0] g1_rdi // rdi code now in force
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] b3_error_mask_r;
   logic [7:0] path_tx_control_0_r;
   logic [7:0] defect_indication_map_0_r;
   logic [7:0] defect_indication_map_1_r;
   logic [7:0] defect_indication_map_2_r;
   logic [7:0] rdi_soft_code_r;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire logic setup = psel && !penable;
   wire logic fire = psel && penable && pready;
   wire logic wr_fire = fire && pwrite;
   wire logic sel_mask = paddr == tpo_pkg::OFS_B3_MASK;
   wire logic sel_ctrl0 = paddr == tpo_pkg::OFS_CTRL0;
   wire logic sel_map2 = paddr == tpo_pkg::OFS_MAP2;
   wire logic sel_map1 = paddr == tpo_pkg::OFS_MAP1;
   wire logic sel_map0 = paddr == tpo_pkg::OFS_MAP0;
   wire logic sel_soft = paddr == tpo_pkg::OFS_RDI_SW;
   wire logic sel_def = paddr == tpo_pkg::OFS_DEFECTS;
   wire logic sel_code = paddr == tpo_pkg::OFS_G1_CODE;
   wire logic hit = sel_mask || sel_ctrl0 || sel_map2 || sel_map1 ||
      sel_map0 || sel_soft || sel_def || sel_code;
   wire logic [7:0] wbyte = pwdata[7:0];

   // ----------------------------------------------------------------
   // defect selection
   // ----------------------------------------------------------------
   wire logic [5:0] defects = {rx_lcd, rx_plm, rx_tim, rx_uneq, rx_lop,
      rx_ais}; // RULE_10
   logic [2:0] auto_code;
   logic auto_hit;
   wire logic [5:0] enables = {
      defect_indication_map_2_r[tpo_pkg::MAP_HI_EN], // RULE_14
      defect_indication_map_2_r[tpo_pkg::MAP_LO_EN], // RULE_13
      defect_indication_map_1_r[tpo_pkg::MAP_HI_EN], // RULE_17
      defect_indication_map_1_r[tpo_pkg::MAP_LO_EN], // RULE_16
      defect_indication_map_0_r[tpo_pkg::MAP_HI_EN],
      defect_indication_map_0_r[tpo_pkg::MAP_LO_EN]};
   wire logic [17:0] codes = {
      defect_indication_map_2_r[tpo_pkg::MAP_HI_CODE +: 3], // RULE_14
      defect_indication_map_2_r[tpo_pkg::MAP_LO_CODE +: 3], // RULE_12
      defect_indication_map_1_r[tpo_pkg::MAP_HI_CODE +: 3], // RULE_18
      defect_indication_map_1_r[tpo_pkg::MAP_LO_CODE +: 3], // RULE_15
      defect_indication_map_0_r[tpo_pkg::MAP_HI_CODE +: 3],
      defect_indication_map_0_r[tpo_pkg::MAP_LO_CODE +: 3]};

   tpo_rdi_sel #(
      .N(tpo_pkg::NUM_DEF),
      .CW(tpo_pkg::CODE_W)
   ) u_sel (
      .defect_i(defects),
      .enable_i(enables),
      .codes_i(codes),
      .code_o(auto_code),
      .hit_o(auto_hit)
   );

   // ----------------------------------------------------------------
   // rdi source and byte path
   // ----------------------------------------------------------------
   wire logic ais_on = path_tx_control_0_r[tpo_pkg::CTRL0_AIS_EN];
   wire logic [1:0] rdi_type =
      path_tx_control_0_r[tpo_pkg::CTRL0_RDI_LO +: 2];
   // type 1x both pick the external port
   wire logic [2:0] rdi_nxt =
      (rdi_type == tpo_pkg::RDI_AUTO) ? auto_code : // RULE_08 RULE_11
      (rdi_type == tpo_pkg::RDI_SOFT) ? rdi_soft_code_r[2:0] :
      ext_path_overhead_in; // RULE_07
   logic [7:0] bip;
   wire logic [7:0] g1_byte = {in_byte[7:4], rdi_nxt,
      in_byte[0]}; // RULE_09
   wire logic force_ones = ais_on && (in_spe || in_ptr_pos);
   wire logic [7:0] out_nxt =
      force_ones ? tpo_pkg::ALL_ONES : // RULE_04 RULE_05
      in_b3_pos ? (bip ^ b3_error_mask_r) : // RULE_02
      in_g1_pos ? g1_byte : in_byte;

   tpo_bip8 #(
      .W(8)
   ) u_bip (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .valid_i(in_valid),
      .spe_i(in_spe),
      .first_i(in_spe_first),
      .byte_i(out_nxt),
      .bip_o(bip)
   );

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire logic [7:0] rd_nxt =
      sel_mask ? b3_error_mask_r :
      sel_ctrl0 ? path_tx_control_0_r :
      sel_map2 ? defect_indication_map_2_r :
      sel_map1 ? defect_indication_map_1_r :
      sel_map0 ? defect_indication_map_0_r :
      sel_soft ? rdi_soft_code_r :
      sel_def ? {2'h0, defects} :
      sel_code ? {auto_hit, 4'h0, g1_rdi} : 8'h00;

   // ----------------------------------------------------------------
   // apb slave: one wait-free access phase
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         pready <= setup;
         if (setup)
         begin
            pslverr <= !hit;
            prdata <= {24'h0, rd_nxt};
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         b3_error_mask_r <= tpo_pkg::RST_B3_MASK; // RULE_01
         path_tx_control_0_r <= tpo_pkg::RST_CTRL0;
         defect_indication_map_0_r <= tpo_pkg::RST_MAP;
         defect_indication_map_1_r <= tpo_pkg::RST_MAP;
         defect_indication_map_2_r <= tpo_pkg::RST_MAP;
         rdi_soft_code_r <= tpo_pkg::RST_RDI_SW;
      end
      else if (wr_fire)
      begin
         if (sel_mask)
            b3_error_mask_r <= wbyte;
         if (sel_ctrl0)
            path_tx_control_0_r <= wbyte & tpo_pkg::CTRL0_WMASK; // RULE_19
         if (sel_map0)
            defect_indication_map_0_r <= wbyte;
         if (sel_map1)
            defect_indication_map_1_r <= wbyte;
         if (sel_map2)
            defect_indication_map_2_r <= wbyte;
         if (sel_soft)
            rdi_soft_code_r <= {5'h0, wbyte[2:0]};
      end
   end

   // ----------------------------------------------------------------
   // outbound stream
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         out_valid <= 1'b0;
         out_byte <= 8'h00;
         src_ready <= 1'b0;
         g1_rdi <= tpo_pkg::RDI_NONE;
      end
      else
      begin
         out_valid <= in_valid;
         if (in_valid)
            out_byte <= out_nxt;
         // ready drops one cycle after ais is set; source must obey it
         src_ready <= !ais_on; // RULE_06
         g1_rdi <= rdi_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_ais_spe;
      @(posedge ref_clk) disable iff (sys_rst)
      in_valid && in_spe && ais_on |=> out_byte == 8'hff;
   endproperty
   a_ais_spe: assert property (p_ais_spe) // RULE_04
      else $error("envelope byte not all ones under ais");

   property p_ais_ptr;
      @(posedge ref_clk) disable iff (sys_rst)
      in_valid && in_ptr_pos && ais_on |=> out_byte == 8'hff;
   endproperty
   a_ais_ptr: assert property (p_ais_ptr) // RULE_05
      else $error("pointer byte not all ones under ais");

   property p_no_cells;
      @(posedge ref_clk) disable iff (sys_rst)
      ais_on ##1 ais_on |-> !src_ready;
   endproperty
   a_no_cells: assert property (p_no_cells) // RULE_06
      else $error("source ready while ais enabled");

   property p_b3_mask;
      @(posedge ref_clk) disable iff (sys_rst)
      in_valid && in_b3_pos && !ais_on |=>
         out_byte == ($past(bip) ^ $past(b3_error_mask_r));
   endproperty
   a_b3_mask: assert property (p_b3_mask) // RULE_02
      else $error("b3 not parity xor mask");

   property p_bip_latch;
      @(posedge ref_clk) disable iff (sys_rst)
      in_valid && in_spe_first ##1 in_valid && in_spe && !in_spe_first
         |=> bip == $past(bip);
   endproperty
   a_bip_latch: assert property (p_bip_latch) // RULE_03
      else $error("bip changed inside an envelope");

   property p_auto_g1;
      @(posedge ref_clk) disable iff (sys_rst)
      in_valid && in_g1_pos && !ais_on && rdi_type == 2'h0 |=>
         out_byte[3:1] == $past(auto_code) &&
         g1_rdi == $past(auto_code);
   endproperty
   a_auto_g1: assert property (p_auto_g1) // RULE_09
      else $error("g1 rdi bits differ from automatic code");

   property p_ais_first;
      @(posedge ref_clk) disable iff (sys_rst)
      rx_ais && defect_indication_map_0_r[0] |->
         auto_code == defect_indication_map_0_r[3:1];
   endproperty
   a_ais_first: assert property (p_ais_first) // RULE_20
      else $error("ais code not given top priority");

   property p_none_zero;
      @(posedge ref_clk) disable iff (sys_rst)
      (defects & enables) == 6'h0 && rdi_type == 2'h0 |=> g1_rdi == 3'h0;
   endproperty
   a_none_zero: assert property (p_none_zero) // RULE_21 RULE_11
      else $error("rdi sent with no enabled defect");

   property p_plm_off;
      @(posedge ref_clk) disable iff (sys_rst)
      defects == 6'h10 && !defect_indication_map_2_r[0] |->
         !auto_hit && auto_code == 3'h0;
   endproperty
   a_plm_off: assert property (p_plm_off) // RULE_13
      else $error("disabled plm altered rdi");

   property p_soft_src;
      @(posedge ref_clk) disable iff (sys_rst)
      rdi_type == 2'h1 |=> g1_rdi == $past(rdi_soft_code_r[2:0]);
   endproperty
   a_soft_src: assert property (p_soft_src) // RULE_07
      else $error("software rdi code not used");

   c_ais: cover property (@(posedge ref_clk) disable iff (sys_rst)
      in_valid && in_spe && ais_on);
   c_b3_err: cover property (@(posedge ref_clk) disable iff (sys_rst)
      in_valid && in_b3_pos && b3_error_mask_r != 8'h00);
   c_multi: cover property (@(posedge ref_clk) disable iff (sys_rst)
      auto_hit && rx_ais && rx_plm);
   c_ext: cover property (@(posedge ref_clk) disable iff (sys_rst)
      in_valid && in_g1_pos && rdi_type[1]);
endmodule
`default_nettype wire

// ===== common/tpo_pkg.sv
// tx path-overhead alarm insertion: register map, fields, reset values
// assumes an 8-bit register file behind a 32-bit apb slave
package tpo_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_B3_MASK = 8'h00;
   localparam logic [7:0] OFS_CTRL0 = 8'h04;
   localparam logic [7:0] OFS_MAP2 = 8'h08;
   localparam logic [7:0] OFS_MAP1 = 8'h0c;
   localparam logic [7:0] OFS_MAP0 = 8'h10;
   localparam logic [7:0] OFS_RDI_SW = 8'h14;
   localparam logic [7:0] OFS_DEFECTS = 8'h18;
   localparam logic [7:0] OFS_G1_CODE = 8'h1c;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_B3_MASK = 8'h00;
   localparam logic [7:0] RST_CTRL0 = 8'h00;
   localparam logic [7:0] RST_MAP = 8'h00;
   localparam logic [7:0] RST_RDI_SW = 8'h00;
   // ----------------------------------------------------------------
   // control byte 0 fields
   // ----------------------------------------------------------------
   localparam int CTRL0_AIS_EN = 0;
   localparam int CTRL0_UNUSED = 1;
   localparam int CTRL0_C2_TYPE = 2;
   localparam int CTRL0_RDI_LO = 3;
   localparam int CTRL0_REI_LO = 5;
   localparam int CTRL0_F2_TYPE = 7;
   localparam logic [7:0] CTRL0_WMASK = 8'hfd;
   localparam logic [1:0] RDI_AUTO = 2'h0;
   localparam logic [1:0] RDI_SOFT = 2'h1;
   // ----------------------------------------------------------------
   // defect map fields: low half {code[3:1], en[0]}, high half {7:5, 4}
   // ----------------------------------------------------------------
   localparam int MAP_LO_EN = 0;
   localparam int MAP_LO_CODE = 1;
   localparam int MAP_HI_EN = 4;
   localparam int MAP_HI_CODE = 5;
   localparam int CODE_W = 3;
   // defect index, lower index wins
   localparam int DEF_AIS = 0;
   localparam int DEF_LOP = 1;
   localparam int DEF_UNEQ = 2;
   localparam int DEF_TIM = 3;
   localparam int DEF_PLM = 4;
   localparam int DEF_LCD = 5;
   localparam int NUM_DEF = 6;
   // g1 rdi bits 5..7 (bit 1 = msb) sit at byte bits 3..1
   localparam int G1_RDI_LO = 1;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [2:0] RDI_NONE = 3'h0;
endpackage

// ===== src/tpo_bip8.sv
// running bip-8 over the bytes of one payload envelope
// assumes first_i marks the first envelope byte, with valid_i
`timescale 1ns/100ps
`default_nettype none
module tpo_bip8 #(
   parameter int W = 8
) (
   input wire logic ref_clk, // clock
   input wire logic sys_rst, // sync reset, high
   input wire logic valid_i, // byte strobe
   input wire logic spe_i, // byte is in the envelope
   input wire logic first_i, // first envelope byte
   input wire logic [W-1:0] byte_i, // byte as transmitted
   output logic [W-1:0] bip_o // parity of previous envelope
);
   logic [W-1:0] acc_r;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         acc_r <= '0;
         bip_o <= '0;
      end
      else if (valid_i && first_i)
      begin
         bip_o <= acc_r; // RULE_03
         acc_r <= byte_i;
      end
      else if (valid_i && spe_i)
      begin
         acc_r <= acc_r ^ byte_i; // RULE_03
      end
   end
endmodule
`default_nettype wire

// ===== src/tpo_rdi_sel.sv
// fixed-priority pick of one rdi code among declared, enabled defects
// assumes index 0 is the highest priority
`timescale 1ns/100ps
`default_nettype none
module tpo_rdi_sel #(
   parameter int N = 6,
   parameter int CW = 3
) (
   input wire logic [N-1:0] defect_i, // declared defects
   input wire logic [N-1:0] enable_i, // per-defect enables
   input wire logic [N*CW-1:0] codes_i, // code per defect
   output logic [CW-1:0] code_o, // chosen code
   output logic hit_o // some enabled defect is up
);
   always_comb
   begin
      code_o = '0; // RULE_21
      hit_o = 1'b0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (defect_i[i] && enable_i[i])
         begin
            code_o = codes_i[i*CW +: CW]; // RULE_20
            hit_o = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verif/tpo_far_end.sv
// far-end path terminating model: recomputes path parity on the
// outbound stream; assumes source flags lead outbound bytes by a cycle
`timescale 1ns/100ps
`default_nettype none
module tpo_far_end (
   input wire logic ref_clk, // byte clock
   input wire logic sys_rst, // sync reset, high
   input wire logic in_valid, // source strobe
   input wire logic in_spe, // byte in envelope
   input wire logic in_spe_first, // first envelope byte
   input wire logic in_b3_pos, // byte is b3
   input wire logic out_valid, // outbound strobe
   input wire logic [7:0] out_byte, // outbound byte
   output logic [7:0] rx_b3, // last b3 received
   output logic [7:0] exp_b3 // parity that b3 should carry
);
   logic f_spe_r, f_first_r, f_b3_r;
   logic [7:0] acc_r, prev_r;
   // ----------------------------------------------------------------
   // parity over bytes as received, latched at each new envelope
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         f_spe_r <= 1'h0;
         f_first_r <= 1'h0;
         f_b3_r <= 1'h0;
         acc_r <= 8'h00;
         prev_r <= 8'h00;
         rx_b3 <= 8'h00;
         exp_b3 <= 8'h00;
      end
      else
      begin
         if (in_valid)
         begin
            f_spe_r <= in_spe;
            f_first_r <= in_spe_first;
            f_b3_r <= in_b3_pos;
         end
         if (out_valid)
         begin
            if (f_first_r)
            begin
               prev_r <= acc_r;
               acc_r <= out_byte;
            end
            else if (f_spe_r)
               acc_r <= acc_r ^ out_byte;
            if (f_b3_r)
            begin
               rx_b3 <= out_byte;
               exp_b3 <= prev_r;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// bench for the tx path alarm block: apb tasks, envelope driver and a
// far-end parity model; assumes one 100 mhz clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, in_byte, out_byte, rx_b3, exp_b3, mask, fr;
   logic [31:0] pwdata, prdata, q;
   logic in_valid, in_spe, in_spe_first, in_b3_pos, in_g1_pos;
   logic in_ptr_pos, out_valid, src_ready, e;
   logic [2:0] ext_rdi, g1_rdi;
   logic [5:0] dfx;
   logic [7:0] seen[$];
   logic [2:0] cd[6];
   int error_cnt, n_checks;
   tpo_path_alarm tpo_path_alarm_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_valid(in_valid), .in_byte(in_byte),
      .in_spe(in_spe), .in_spe_first(in_spe_first),
      .in_b3_pos(in_b3_pos), .in_g1_pos(in_g1_pos),
      .in_ptr_pos(in_ptr_pos), .ext_path_overhead_in(ext_rdi),
      .rx_ais(dfx[0]), .rx_lop(dfx[1]), .rx_uneq(dfx[2]),
      .rx_tim(dfx[3]), .rx_plm(dfx[4]), .rx_lcd(dfx[5]),
      .out_valid(out_valid), .out_byte(out_byte),
      .src_ready(src_ready), .g1_rdi(g1_rdi));
   tpo_far_end tpo_far_end_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .in_valid(in_valid),
      .in_spe(in_spe), .in_spe_first(in_spe_first),
      .in_b3_pos(in_b3_pos), .out_valid(out_valid),
      .out_byte(out_byte), .rx_b3(rx_b3), .exp_b3(exp_b3));
   // ----------------------------------------------------------------
   // clock, output monitor, watchdog
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (out_valid === 1'h1)
         seen.push_back(out_byte);
   initial
   begin
      #100000;
      error_cnt++;
      report_and_stop();
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] x);
      n_checks++;
      if (s !== x)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask
   // master holds the request until pready is sampled high or 20 further cycles pass
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      @(posedge ref_clk);
      while (pready !== 1'h1 && n < 20)
      begin
         n++;
         @(posedge ref_clk);
      end
      chk("pready", {31'h0, pready}, 32'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'h1, a, {24'h0, d});
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [7:0] x);
      apb(1'h0, a, 32'h0);
      chk(nm, q, {24'h0, x});
   endtask
   task automatic rdi_is(input logic [2:0] x);
      repeat (3) @(posedge ref_clk);
      chk("g1_rdi", {29'h0, g1_rdi}, {29'h0, x});
   endtask
   function automatic logic [7:0] pat(input int i);
      return 8'h13 * 8'(i) + fr;
   endfunction
   // envelope: pointer byte, j1, b3, g1, three payload bytes
   task automatic frame(input logic ais, input logic [2:0] code,
                        input logic pb);
      logic [7:0] b;
      logic [7:0] x;
      seen.delete();
      for (int i = 0; i < 7; i++)
      begin
         @(posedge ref_clk);
         in_valid <= 1'h1;
         in_byte <= pat(i);
         in_ptr_pos <= (i == 0);
         in_spe <= (i != 0);
         in_spe_first <= (i == 1);
         in_b3_pos <= (i == 2);
         in_g1_pos <= (i == 3);
      end
      @(posedge ref_clk);
      in_valid <= 1'h0;
      repeat (3) @(posedge ref_clk);
      chk("count", 32'(seen.size()), 32'h7);
      for (int i = 0; i < 7 && i < seen.size(); i++)
      begin
         b = pat(i);
         x = ais ? 8'hff : (i == 3 ? {b[7:4], code, b[0]} : b);
         if (ais || i != 2)
            chk("out_byte", 32'(seen[i]), 32'(x));
      end
      chk("src_ready", {31'h0, src_ready}, {31'h0, !ais});
      if (pb)
         chk("b3", {24'h0, rx_b3}, {24'h0, exp_b3 ^ mask});
      fr = fr + 8'h07;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {psel, penable, pwrite, in_valid, in_spe, in_spe_first} = 6'h0;
      {in_b3_pos, in_g1_pos, in_ptr_pos} = 3'h0;
      {paddr, in_byte, mask, fr, pwdata, ext_rdi, dfx} = 73'h0;
      cd = '{3'h1, 3'h7, 3'h2, 3'h6, 3'h3, 3'h5};
      sys_rst = 1'h1;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'h0;
      rd("mask_rst", tpo_pkg::OFS_B3_MASK, 8'h00);
      rd("ctrl0_rst", tpo_pkg::OFS_CTRL0, 8'h00);
      rd("map2_rst", tpo_pkg::OFS_MAP2, tpo_pkg::RST_MAP);
      rd("map1_rst", tpo_pkg::OFS_MAP1, tpo_pkg::RST_MAP);
      rd("unmapped", 8'h20, 8'h00);
      chk("slverr", {31'h0, e}, 32'h1);
      wr(tpo_pkg::OFS_CTRL0, 8'hff);
      rd("ctrl0_ro", tpo_pkg::OFS_CTRL0, 8'hfd);
      wr(tpo_pkg::OFS_CTRL0, 8'he4);
      rd("ctrl0_flds", tpo_pkg::OFS_CTRL0, 8'he4);
      wr(tpo_pkg::OFS_CTRL0, 8'h00);
      frame(1'h0, 3'h0, 1'h0);
      frame(1'h0, 3'h0, 1'h1);
      mask = 8'h5a;
      wr(tpo_pkg::OFS_B3_MASK, mask);
      rd("mask", tpo_pkg::OFS_B3_MASK, 8'h5a);
      frame(1'h0, 3'h0, 1'h1);
      wr(tpo_pkg::OFS_CTRL0, 8'h01);
      frame(1'h1, 3'h0, 1'h0);
      wr(tpo_pkg::OFS_CTRL0, 8'h00);
      frame(1'h0, 3'h0, 1'h1);
      wr(tpo_pkg::OFS_MAP0, 8'hf3);
      wr(tpo_pkg::OFS_MAP1, 8'hd5);
      wr(tpo_pkg::OFS_MAP2, 8'hb7);
      for (int k = 0; k < 6; k++)
      begin
         dfx <= 6'(6'h1 << k);
         rdi_is(cd[k]);
         dfx <= 6'(6'h3f << k);
         rdi_is(cd[k]);
      end
      dfx <= 6'h04;
      frame(1'h0, 3'h2, 1'h1);
      dfx <= 6'h00;
      rdi_is(3'h0);
      wr(tpo_pkg::OFS_MAP1, 8'hd4);
      dfx <= 6'h04;
      rdi_is(3'h0);
      wr(tpo_pkg::OFS_MAP2, 8'hb6);
      dfx <= 6'h10;
      rdi_is(3'h0);
      wr(tpo_pkg::OFS_RDI_SW, 8'h04);
      wr(tpo_pkg::OFS_CTRL0, 8'h08);
      rdi_is(3'h4);
      ext_rdi <= 3'h5;
      wr(tpo_pkg::OFS_CTRL0, 8'h10);
      rdi_is(3'h5);
      wr(tpo_pkg::OFS_CTRL0, 8'h18);
      rdi_is(3'h5);
      dfx <= 6'h01;
      wr(tpo_pkg::OFS_CTRL0, 8'h00);
      rdi_is(3'h1);
      report_and_stop();
   end
endmodule
`default_nettype wire
